// ---- verilog/cfg_header.sv ----
// Configuration header and memory window decode for the video controller.
`timescale 1ns/1ns

module cfg_header (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic resetn_in,
   // Target request from the bus front end.
   input wire logic req_valid_in,
   input wire logic req_is_cfg_in,
   input wire logic req_write_in,
   input wire logic [31:0] req_addr_in,
   input wire logic [3:0] req_byte_en_in,
   input wire logic [31:0] req_wdata_in,
   // Target answer.
   output logic done_out,
   output logic claim_out,
   output logic [31:0] rdata_out,
   // Initiator side.
   input wire logic master_want_in,
   input wire logic burst_start_in,
   input wire logic burst_active_in,
   input wire logic grant_in,
   output logic master_permit_out,
   output logic burst_stop_out,
   // Controls to the rest of the device.
   output logic soft_reset_out,
   output logic video_capture_on_out,
   output logic single_picture_mode_out,
   output logic picture_grab_request_out,
   output logic compressed_read_on_out,
   output logic jpeg_hold_out,
   output logic [31:0] horiz_config_out
);

   // ************************************************************
   // Storage.
   // ************************************************************

   logic mem_enable;
   logic master_enable;
   logic [7:0] latency_timer;
   logic [31:0] memory_window_base;
   logic [7:0] interrupt_line;
   logic [31:0] horiz_config;
   logic [31:0] video_ctrl;
   logic [31:0] system_ctrl;
   logic [31:0] code_ctrl;
   logic soft_reset;
   logic cfg_wr;
   logic app_hit;
   logic app_wr;
   logic [11:0] app_off;
   logic [7:0] cfg_off;
   logic [31:0] next_rdata;
   logic [15:0] command_view;

   // Merge write data into a register over enabled lanes and writable bits.
   function automatic logic [31:0] lane_merge(input logic [31:0] old_value,
                                              input logic [31:0] new_value,
                                              input logic [3:0] byte_en,
                                              input logic [31:0] wmask);
      logic [31:0] lanes;
      lanes = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}};
      lane_merge = (old_value & ~(lanes & wmask)) | (new_value & lanes & wmask);
   endfunction : lane_merge

   // ************************************************************
   // Decode.
   // ************************************************************

   // Low address bits are dropped: every register is one aligned word.
   assign cfg_off = {req_addr_in[7:2], 2'b00};
   assign app_off = {req_addr_in[11:2], 2'b00};
   assign cfg_wr = req_valid_in && req_is_cfg_in && req_write_in;
   // The window claims only with memory space enabled and the base matched.
   assign app_hit = req_valid_in && !req_is_cfg_in && mem_enable
                    && req_addr_in[31:cfg_header_pkg::WINDOW_BITS]
                       == memory_window_base[31:cfg_header_pkg::WINDOW_BITS];
   // Video, code and horizontal values are not latched while the device sits in soft reset.
   assign app_wr = app_hit && req_write_in && !soft_reset;
   assign soft_reset = !system_ctrl[cfg_header_pkg::SYS_RUN_BIT];
   // Only bits 2 and 1 exist; all other command bits read as zero.
   assign command_view = {13'h0000, master_enable, mem_enable, 1'b0};

   // ************************************************************
   // Configuration header registers (hardware reset only).
   // ************************************************************

   // Command word: only the memory and master permissions are writable.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mem_enable <= 1'b0;
         master_enable <= 1'b0;
      end else if (cfg_wr && cfg_off == cfg_header_pkg::CFG_COMMAND
                   && req_byte_en_in[0]) begin
         mem_enable <= req_wdata_in[cfg_header_pkg::CMD_MEM_BIT];
         master_enable <= req_wdata_in[cfg_header_pkg::CMD_MASTER_BIT];
      end
   end

   // Latency timer keeps its three low bits at zero.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         latency_timer <= cfg_header_pkg::LAT_TIMER_RESET;
      end else if (cfg_wr && cfg_off == cfg_header_pkg::CFG_HDR_LAT
                   && req_byte_en_in[1]) begin
         latency_timer <= req_wdata_in[15:8] & cfg_header_pkg::LAT_TIMER_WMASK;
      end
   end

   // Memory base: low twelve bits fixed at zero give a 4 KB aligned window.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         memory_window_base <= 32'h0000_0000;
      end else if (cfg_wr && cfg_off == cfg_header_pkg::CFG_MEM_BASE) begin
         memory_window_base <= lane_merge(memory_window_base, req_wdata_in,
                                          req_byte_en_in,
                                          cfg_header_pkg::MEM_BASE_WMASK);
      end
   end

   // Interrupt line is stored for software only and drives nothing.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         interrupt_line <= cfg_header_pkg::INT_LINE_RESET;
      end else if (cfg_wr && cfg_off == cfg_header_pkg::CFG_INT_HINTS
                   && req_byte_en_in[0]) begin
         interrupt_line <= req_wdata_in[7:0];
      end
   end

   // ************************************************************
   // Application registers.
   // ************************************************************

   // System control stays writable in soft reset so software can release it; soft reset sets its JPEG hold bit.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         system_ctrl <= cfg_header_pkg::SYSTEM_RESET;
      end else if (app_hit && req_write_in
                   && app_off == cfg_header_pkg::APP_SYSTEM_CTRL) begin
         system_ctrl <= lane_merge(system_ctrl, req_wdata_in, req_byte_en_in,
                                   cfg_header_pkg::SYSTEM_WMASK);
      end else if (soft_reset) begin
         system_ctrl[cfg_header_pkg::SYS_JPEG_HOLD_BIT] <= 1'b1;
      end
   end

   // Video controls return to defaults throughout soft reset.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         video_ctrl <= cfg_header_pkg::VIDEO_RESET;
      end else if (soft_reset) begin
         video_ctrl <= cfg_header_pkg::VIDEO_RESET;
      end else if (app_wr && app_off == cfg_header_pkg::APP_VIDEO_CTRL) begin
         video_ctrl <= lane_merge(video_ctrl, req_wdata_in, req_byte_en_in,
                                  cfg_header_pkg::VIDEO_WMASK);
      end
   end

   // Code controls return to defaults throughout soft reset.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         code_ctrl <= cfg_header_pkg::CODE_RESET;
      end else if (soft_reset) begin
         code_ctrl <= cfg_header_pkg::CODE_RESET;
      end else if (app_wr && app_off == cfg_header_pkg::APP_CODE_CTRL) begin
         code_ctrl <= lane_merge(code_ctrl, req_wdata_in, req_byte_en_in,
                                 cfg_header_pkg::CODE_WMASK);
      end
   end

   // Horizontal front-end setup; changing it mid-capture is software's
   // hazard, so no interlock is built here.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         horiz_config <= cfg_header_pkg::HORIZ_RESET;
      end else if (soft_reset) begin
         horiz_config <= cfg_header_pkg::HORIZ_RESET;
      end else if (app_wr && app_off == cfg_header_pkg::APP_HORIZ) begin
         horiz_config <= lane_merge(horiz_config, req_wdata_in, req_byte_en_in,
                                    cfg_header_pkg::HORIZ_WMASK);
      end
   end

   // ************************************************************
   // Read data.
   // ************************************************************

   // Reads return whole words; byte enables only matter to the bus.
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (req_is_cfg_in) begin
         if (cfg_off == cfg_header_pkg::CFG_IDENT) begin
            next_rdata = cfg_header_pkg::IDENT_DEFAULT;
         end else if (cfg_off == cfg_header_pkg::CFG_COMMAND) begin
            next_rdata = {16'h0000, command_view};
         end else if (cfg_off == cfg_header_pkg::CFG_CLASS_REV) begin
            next_rdata = {cfg_header_pkg::CLASS_CODE,
                          cfg_header_pkg::REVISION_DEFAULT};
         end else if (cfg_off == cfg_header_pkg::CFG_HDR_LAT) begin
            next_rdata = {16'h0000, latency_timer, 8'h00};
         end else if (cfg_off == cfg_header_pkg::CFG_MEM_BASE) begin
            next_rdata = memory_window_base;
         end else if (cfg_off == cfg_header_pkg::CFG_INT_HINTS) begin
            next_rdata = {cfg_header_pkg::MAX_LAT_HINT,
                          cfg_header_pkg::MIN_GNT_HINT,
                          cfg_header_pkg::INT_PIN_VALUE,
                          interrupt_line};
         end
      end else begin
         if (app_off == cfg_header_pkg::APP_HORIZ) begin
            next_rdata = horiz_config;
         end else if (app_off == cfg_header_pkg::APP_VIDEO_CTRL) begin
            next_rdata = video_ctrl;
         end else if (app_off == cfg_header_pkg::APP_SYSTEM_CTRL) begin
            next_rdata = system_ctrl;
         end else if (app_off == cfg_header_pkg::APP_CODE_CTRL) begin
            next_rdata = code_ctrl;
         end
      end
   end

   // ************************************************************
   // Answer.
   // ************************************************************

   // Every request completes one cycle later; claim shows whether we took it.
   // Configuration writes to fixed fields still complete normally.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         done_out <= 1'b0;
         claim_out <= 1'b0;
         rdata_out <= 32'h0000_0000;
      end else begin
         done_out <= req_valid_in;
         claim_out <= (req_valid_in && req_is_cfg_in) || app_hit;
         if ((req_valid_in && req_is_cfg_in) || app_hit) begin
            rdata_out <= req_write_in ? 32'h0000_0000 : next_rdata;
         end else begin
            rdata_out <= 32'h0000_0000;
         end
      end
   end

   // ************************************************************
   // Initiator permission and device controls.
   // ************************************************************

   // The initiator may start only with mastering enabled and outside soft reset.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         master_permit_out <= 1'b0;
      end else begin
         master_permit_out <= master_want_in && master_enable && !soft_reset;
      end
   end

   // Control outputs are registered copies so they are clean flop outputs.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         soft_reset_out <= 1'b1;
         video_capture_on_out <= 1'b0;
         single_picture_mode_out <= 1'b0;
         picture_grab_request_out <= 1'b0;
         compressed_read_on_out <= 1'b0;
         jpeg_hold_out <= 1'b1;
         horiz_config_out <= cfg_header_pkg::HORIZ_RESET;
      end else begin
         soft_reset_out <= soft_reset;
         video_capture_on_out <= video_ctrl[cfg_header_pkg::VID_ON_BIT];
         single_picture_mode_out <= video_ctrl[cfg_header_pkg::VID_SINGLE_BIT];
         picture_grab_request_out <= video_ctrl[cfg_header_pkg::VID_GRAB_BIT];
         compressed_read_on_out <= code_ctrl[cfg_header_pkg::CODE_ON_BIT];
         jpeg_hold_out <= system_ctrl[cfg_header_pkg::SYS_JPEG_HOLD_BIT];
         horiz_config_out <= horiz_config;
      end
   end

   // ************************************************************
   // Burst limiter.
   // ************************************************************

   burst_limit limiter (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .latency_count_in(latency_timer),
      .burst_start_in(burst_start_in),
      .burst_active_in(burst_active_in),
      .grant_in(grant_in),
      .burst_stop_out(burst_stop_out)
   );

endmodule : cfg_header

// ---- verilog/cfg_header_pkg.sv ----
// Constants for the configuration header and application register window.
package cfg_header_pkg;

   // ************************************************************
   // Configuration header offsets (byte addresses).
   // ************************************************************
   localparam logic [7:0] CFG_IDENT = 8'h00;
   localparam logic [7:0] CFG_COMMAND = 8'h04;
   localparam logic [7:0] CFG_CLASS_REV = 8'h08;
   localparam logic [7:0] CFG_HDR_LAT = 8'h0c;
   localparam logic [7:0] CFG_MEM_BASE = 8'h10;
   localparam logic [7:0] CFG_INT_HINTS = 8'h3c;

   // ************************************************************
   // Command word fields.
   // ************************************************************
   localparam int CMD_MEM_BIT = 1;
   localparam int CMD_MASTER_BIT = 2;

   // ************************************************************
   // Fixed read-back values, reset values and write masks.
   // ************************************************************
   localparam logic [23:0] CLASS_CODE = 24'h040000;
   localparam logic [7:0] REVISION_DEFAULT = 8'h5a; // Arbitrary value.
   localparam logic [31:0] IDENT_DEFAULT = 32'h0000_0000; // Arbitrary value.
   localparam logic [7:0] MAX_LAT_HINT = 8'h10;
   localparam logic [7:0] MIN_GNT_HINT = 8'h02;
   localparam logic [7:0] INT_PIN_VALUE = 8'h01;
   localparam logic [7:0] INT_LINE_RESET = 8'h0a;
   localparam logic [7:0] LAT_TIMER_RESET = 8'h00;
   localparam logic [7:0] LAT_TIMER_WMASK = 8'hf8;
   localparam logic [31:0] MEM_BASE_WMASK = 32'hffff_f000;
   localparam int WINDOW_BITS = 12;

   // ************************************************************
   // Application register offsets within the 4 KB window.
   // ************************************************************
   localparam logic [11:0] APP_HORIZ = 12'h000;
   localparam logic [11:0] APP_VIDEO_CTRL = 12'h028;
   localparam logic [11:0] APP_SYSTEM_CTRL = 12'h03c;
   localparam logic [11:0] APP_CODE_CTRL = 12'h100;

   // Horizontal register: polarity bit 30, start 19:10, end 9:0.
   localparam logic [31:0] HORIZ_WMASK = 32'h400f_ffff;
   localparam logic [31:0] HORIZ_RESET = 32'h0000_07ff;
   // Video control: bit 0 capture on, bit 1 single picture, bit 2 grab request.
   localparam int VID_ON_BIT = 0;
   localparam int VID_SINGLE_BIT = 1;
   localparam int VID_GRAB_BIT = 2;
   localparam logic [31:0] VIDEO_WMASK = 32'h0000_0007;
   localparam logic [31:0] VIDEO_RESET = 32'h0000_0000;
   // System control: bit 0 run (0 holds soft reset), bit 1 JPEG process reset.
   localparam int SYS_RUN_BIT = 0;
   localparam int SYS_JPEG_HOLD_BIT = 1;
   localparam logic [31:0] SYSTEM_WMASK = 32'h0000_0003;
   localparam logic [31:0] SYSTEM_RESET = 32'h0000_0002;
   // Code control: bit 0 compressed read on.
   localparam int CODE_ON_BIT = 0;
   localparam logic [31:0] CODE_WMASK = 32'h0000_0001;
   localparam logic [31:0] CODE_RESET = 32'h0000_0000;

endpackage : cfg_header_pkg

// ---- verilog/burst_limit.sv ----
// Latency-timer burst limiter for bursts started by the device as initiator.
`timescale 1ns/1ns

module burst_limit (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic resetn_in,
   // Programmed latency count and bus state.
   input wire logic [7:0] latency_count_in,
   input wire logic burst_start_in,
   input wire logic burst_active_in,
   input wire logic grant_in,
   // Request to end the burst.
   output logic burst_stop_out
);

   logic [7:0] remaining;

   // ************************************************************
   // Countdown.
   // ************************************************************

   // The count is loaded at each burst start and runs down once per clock while the burst is active, stopping at zero.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         remaining <= 8'h00;
      end else if (burst_start_in) begin
         remaining <= latency_count_in;
      end else if (burst_active_in && remaining != 8'h00) begin
         remaining <= remaining - 8'h01;
      end
   end

   // Stop only once the count is spent and the grant has gone away.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         burst_stop_out <= 1'b0;
      end else begin
         burst_stop_out <= burst_active_in && !burst_start_in && !grant_in
                           && remaining == 8'h00;
      end
   end

endmodule : burst_limit

// ---- verif/cfg_header_chk.sv ----
// Port checker for the configuration header block.
`timescale 1ns/1ns

module cfg_header_chk (
   // Clock, reset.
   input wire logic clock_in,
   input wire logic resetn_in,
   // Target path.
   input wire logic req_valid_in,
   input wire logic req_is_cfg_in,
   input wire logic req_write_in,
   input wire logic [31:0] req_addr_in,
   input wire logic done_out,
   input wire logic claim_out,
   input wire logic [31:0] rdata_out,
   // Initiator path.
   input wire logic master_want_in,
   input wire logic burst_active_in,
   input wire logic grant_in,
   input wire logic master_permit_out,
   input wire logic burst_stop_out
);
   localparam logic [31:0] cls = {cfg_header_pkg::CLASS_CODE, cfg_header_pkg::REVISION_DEFAULT};
   localparam logic [23:0] hints = {8'h10, 8'h02, 8'h01};
   logic cfg_rd;
   logic [5:0] w;

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!resetn_in);

   // Configuration reads by word offset.
   assign cfg_rd = req_valid_in && req_is_cfg_in && !req_write_in;
   assign w = req_addr_in[7:2];

   // ******
   // Assertions.
   // ******
   done_next_a: assert property (req_valid_in |=> done_out) else $error("no answer");
   done_cause_a: assert property (done_out |-> $past(req_valid_in) &&
      (claim_out || !$past(req_is_cfg_in))) else $error("bad answer");
   write_zero_a: assert property (req_valid_in && req_write_in |=> rdata_out == 32'h0)
      else $error("write data");
   class_word_a: assert property (cfg_rd && w == 6'h02 |=> rdata_out == cls)
      else $error("class word");
   header_zero_a: assert property (cfg_rd && w == 6'h03 |=>
      rdata_out[31:16] == 16'h0 && rdata_out[10:0] == 11'h0) else $error("header word");
   hint_word_a: assert property (cfg_rd && w == 6'h0f |=> rdata_out[31:8] == hints)
      else $error("hint word");
   hole_zero_a: assert property (cfg_rd && w >= 6'h05 && w <= 6'h0e |=> rdata_out == 32'h0)
      else $error("hole word");
   command_fixed_a: assert property (cfg_rd && w == 6'h01 |=>
      rdata_out[9:3] == 7'h0 && !rdata_out[0]) else $error("command word");
   base_align_a: assert property (cfg_rd && w == 6'h04 |=> rdata_out[11:0] == 12'h0)
      else $error("base word");
   stop_cause_a: assert property (burst_stop_out |->
      $past(burst_active_in) && !$past(grant_in)) else $error("early stop");
   permit_cause_a: assert property (master_permit_out |-> $past(master_want_in))
      else $error("permit");

   // Main scenarios reached.
   stop_seen_c: cover property (burst_stop_out);
   unclaimed_c: cover property (done_out && !claim_out);
   permit_c: cover property (master_permit_out ##1 !master_permit_out);
endmodule : cfg_header_chk

bind cfg_header cfg_header_chk i_cfg_header_chk (.clock_in(clock_in), .resetn_in(resetn_in),
   .req_valid_in(req_valid_in), .req_is_cfg_in(req_is_cfg_in), .req_write_in(req_write_in),
   .req_addr_in(req_addr_in), .done_out(done_out), .claim_out(claim_out),
   .rdata_out(rdata_out), .master_want_in(master_want_in), .burst_active_in(burst_active_in),
   .grant_in(grant_in), .master_permit_out(master_permit_out), .burst_stop_out(burst_stop_out));

// ---- verif/bus_arbiter_model.sv ----
// Arbiter and burst engine on the far side of the initiator path.
`timescale 1ns/1ns

module bus_arbiter_model (
   // Clock, reset.
   input wire logic clock_in,
   input wire logic resetn_in,
   // Requests and limits.
   input wire logic want_in,
   input wire logic permit_in,
   input wire logic stop_in,
   input wire logic [3:0] hold_in,
   // Burst state.
   output logic start_out,
   output logic active_out,
   output logic grant_out
);
   logic [3:0] left;

   // Grant is withdrawn hold_in + 1 cycles into a burst.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         start_out <= 1'b0;
         active_out <= 1'b0;
         grant_out <= 1'b0;
         left <= 4'h0;
      end else begin
         start_out <= 1'b0;
         if (!active_out && want_in && permit_in) begin
            start_out <= 1'b1;
            active_out <= 1'b1;
            grant_out <= 1'b1;
            left <= hold_in;
         end else if (active_out && stop_in) begin
            active_out <= 1'b0;
            grant_out <= 1'b0;
         end else if (left != 4'h0) begin
            left <= left - 4'h1;
         end else begin
            grant_out <= 1'b0;
         end
      end
   end
endmodule : bus_arbiter_model

// ---- verif/testbench.sv ----
// Self-checking testbench for the configuration header block.
`timescale 1ns/1ns

module testbench;
   localparam logic [23:0] hints = {8'h10, 8'h02, 8'h01};
   localparam logic [32:0] ack = 33'h1_0000_0000;
   logic clock_in = 1'b0;
   logic resetn_in;
   logic req_valid_in = 1'b0;
   logic req_is_cfg_in = 1'b0;
   logic req_write_in = 1'b0;
   logic master_want_in = 1'b0;
   logic [3:0] req_byte_en_in = 4'h0;
   logic [3:0] hold_in = 4'h2;
   logic [31:0] req_addr_in = 32'h0;
   logic [31:0] req_wdata_in = 32'h0;
   logic burst_start_in, burst_active_in, grant_in, done_out, claim_out, burst_stop_out;
   logic master_permit_out, soft_reset_out, video_capture_on_out, single_picture_mode_out;
   logic picture_grab_request_out, compressed_read_on_out, jpeg_hold_out;
   logic [31:0] rdata_out, horiz_config_out, base, hz, wd, m;
   logic [3:0] be;
   logic [32:0] expect_q[$];
   int errors = 0;
   int samples_checked = 0;
   int n;
   int holds[2] = '{2, 12};

   cfg_header i_cfg_header (.clock_in(clock_in), .resetn_in(resetn_in),
      .req_valid_in(req_valid_in), .req_is_cfg_in(req_is_cfg_in), .req_write_in(req_write_in),
      .req_addr_in(req_addr_in), .req_byte_en_in(req_byte_en_in), .req_wdata_in(req_wdata_in),
      .done_out(done_out), .claim_out(claim_out), .rdata_out(rdata_out),
      .master_want_in(master_want_in), .burst_start_in(burst_start_in),
      .burst_active_in(burst_active_in), .grant_in(grant_in),
      .master_permit_out(master_permit_out), .burst_stop_out(burst_stop_out),
      .soft_reset_out(soft_reset_out), .video_capture_on_out(video_capture_on_out),
      .single_picture_mode_out(single_picture_mode_out),
      .picture_grab_request_out(picture_grab_request_out),
      .compressed_read_on_out(compressed_read_on_out), .jpeg_hold_out(jpeg_hold_out),
      .horiz_config_out(horiz_config_out));

   bus_arbiter_model i_bus_arbiter_model (.clock_in(clock_in), .resetn_in(resetn_in),
      .want_in(master_want_in), .permit_in(master_permit_out), .stop_in(burst_stop_out),
      .hold_in(hold_in), .start_out(burst_start_in), .active_out(burst_active_in),
      .grant_out(grant_in));

   // ******
   // Clock, tasks and answer monitor.
   // ******
   initial begin
      forever #2 clock_in = ~clock_in;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         errors++;
         $display("FAIL %0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic stop_test;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   // One request per call; e is the expected claim and read data.
   task automatic acc(input logic c, input logic r, input logic [31:0] a, input logic [3:0] b,
      input logic [31:0] d, input logic [32:0] e);
      @(posedge clock_in);
      req_valid_in <= 1'b1;
      req_is_cfg_in <= c;
      req_write_in <= r;
      req_addr_in <= a;
      req_byte_en_in <= b;
      req_wdata_in <= d;
      expect_q.push_back(e);
   endtask : acc

   task automatic idle(input int c);
      @(posedge clock_in);
      req_valid_in <= 1'b0;
      repeat (c) @(posedge clock_in);
   endtask : idle

   // A wait that runs out ends the run as a mismatch.
   task automatic wait_hi(ref logic s, input int lim);
      for (n = 0; n < lim && s !== 1'b1; n++)
         @(posedge clock_in);
      if (n == lim) begin
         errors++;
         stop_test();
      end
   endtask : wait_hi

   // Answers are matched against the oldest expectation.
   always @(posedge clock_in) begin
      if (done_out === 1'b1) begin
         check({31'h0, claim_out}, {31'h0, expect_q[0][32]});
         check(rdata_out, expect_q[0][31:0]);
         void'(expect_q.pop_front());
      end
   end

   initial begin
      resetn_in = 1'b0;
      void'($urandom(32'h2b26e3e4));
      base = $urandom & cfg_header_pkg::MEM_BASE_WMASK;
      wd = $urandom;
      repeat (8) @(posedge clock_in);
      resetn_in <= 1'b1;
      // Reset values, holes and a read before the window is enabled.
      acc(1, 0, 32'h04, 4'hf, wd, ack);
      acc(1, 0, 32'h08, 4'hf, wd, {1'b1, cfg_header_pkg::CLASS_CODE, 8'h5a});
      acc(1, 0, 32'h0c, 4'hf, wd, ack);
      acc(1, 0, 32'h10, 4'hf, wd, ack);
      acc(1, 0, 32'h3c, 4'hf, wd, {1'b1, hints, 8'h0a});
      for (int a = 32'h14; a < 32'h3c; a += 4)
         acc(1, 0, a, 4'hf, wd, ack);
      acc(0, 0, base, 4'hf, wd, 33'h0);
      // Write the command, class, latency, base and interrupt words; the base only once.
      acc(1, 1, 32'h04, 4'hf, 32'hffff_ffff, ack);
      acc(1, 1, 32'h08, 4'hf, wd, ack);
      acc(1, 1, 32'h0c, 4'hf, 32'hffff_ffff, ack);
      acc(1, 1, 32'h10, 4'hf, base | 32'hfff, ack);
      acc(1, 1, 32'h3c, 4'hf, wd, ack);
      acc(1, 0, 32'h04, 4'hf, wd, 33'h1_0000_0006);
      acc(1, 0, 32'h0c, 4'hf, wd, 33'h1_0000_f800);
      acc(1, 0, 32'h10, 4'hf, wd, {1'b1, base});
      acc(1, 0, 32'h3c, 4'hf, wd, {1'b1, hints, wd[7:0]});
      // Window decode during soft reset.
      acc(0, 0, base + 32'h03c, 4'hf, wd, 33'h1_0000_0002);
      acc(0, 1, base + 32'h028, 4'hf, 32'h7, ack);
      acc(0, 0, base + 32'h028, 4'hf, wd, ack);
      acc(0, 0, base + 32'h004, 4'hf, wd, ack);
      acc(0, 0, base + 32'hffc, 4'hf, wd, ack);
      acc(0, 0, base + 32'h1000, 4'hf, wd, 33'h0);
      acc(0, 0, base - 32'h4, 4'hf, wd, 33'h0);
      acc(0, 1, base + 32'h03c, 4'h1, 32'h1, ack);
      idle(3);
      check({31'h0, soft_reset_out | jpeg_hold_out}, 32'h0);
      // Random byte lanes into the horizontal register.
      hz = cfg_header_pkg::HORIZ_RESET;
      repeat (6) begin
         be = $urandom;
         wd = $urandom;
         m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & cfg_header_pkg::HORIZ_WMASK;
         hz = (hz & ~m) | (wd & m);
         acc(0, 1, base, be, wd, ack);
         acc(0, 0, base, be, wd, {1'b1, hz});
      end
      acc(0, 1, base + 32'h028, 4'h1, 32'h7, ack);
      acc(0, 1, base + 32'h100, 4'h1, 32'h1, ack);
      acc(1, 1, 32'h0c, 4'h2, 32'h0000_0d00, ack);
      idle(3);
      check(horiz_config_out, hz);
      check({28'h0, video_capture_on_out, single_picture_mode_out, picture_grab_request_out,
         compressed_read_on_out}, 32'hf);
      // Bursts cut by a latency count of 8, with a short and a long grant.
      foreach (holds[i]) begin
         hold_in <= holds[i];
         master_want_in <= 1'b1;
         wait_hi(burst_start_in, 20);
         master_want_in <= 1'b0;
         wait_hi(burst_stop_out, 300);
         m = holds[i] > 8 ? holds[i] : 8;
         check({31'h0, n >= m - 1 && n <= m + 4}, 32'h1);
         idle(3);
      end
      // A second soft reset clears the controls and leaves the header alone.
      // The initiator asks only once the soft reset is in force.
      acc(0, 1, base + 32'h03c, 4'h1, 32'h0, ack);
      acc(1, 0, 32'h10, 4'hf, wd, {1'b1, base});
      master_want_in <= 1'b1;
      acc(1, 0, 32'h0c, 4'hf, wd, 33'h1_0000_0800);
      idle(3);
      check({28'h0, video_capture_on_out, compressed_read_on_out, jpeg_hold_out,
         soft_reset_out}, 32'h3);
      check({31'h0, master_permit_out | burst_active_in}, 32'h0);
      master_want_in <= 1'b0;
      acc(1, 1, 32'h04, 4'h1, 32'h0, ack);
      acc(0, 0, base + 32'h03c, 4'hf, wd, 33'h0);
      idle(4);
      check(expect_q.size(), 32'h0);
      stop_test();
   end
endmodule : testbench
